//--- src/cpd_cfg.svh
// constants of the measurement pdo node: offsets, resets, timing
// How it works
// - boot into pre-operational, no pdo before start
// - five nmt commands change the node state
// - bootup frame, heartbeat carries nmt state
// - payload: value lsb first, status, alarm
// - value is signed 32, scaled by digits
// - scale write leaves digits alone
// - unit write leaves scale and digits alone
// - input status: bit1 pos, bit2 neg overflow
// - threshold compare drives switch outputs
// - alarm status: bit0 switch1, bit1 switch2
// - send only operational with valid bit clear
// - type 255: event timer or delta trigger
// - type 254 ignores the event timer
// - nonzero inhibit time blocks pdo sends for inhibit x 100 us after each send
// - defaults 500 kbit/s, node 0x40, type 255
// - event timer defaults to 0x03E8 ms
// - delta defaults to zero, disabled
// - heartbeat default zero, bootup still sent
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH
// register byte offsets
`define CPD_A_PDO_COMM  8'h00
`define CPD_A_TX_TYPE   8'h04
`define CPD_A_INHIBIT   8'h08
`define CPD_A_EVT_TMR   8'h0C
`define CPD_A_DELTA     8'h10
`define CPD_A_HB_TIME   8'h14
`define CPD_A_THRESH1   8'h18
`define CPD_A_THRESH2   8'h1C
`define CPD_A_NODE_ID   8'h20
`define CPD_A_SCALE     8'h24
`define CPD_A_DIGITS    8'h28
`define CPD_A_UNIT      8'h2C
`define CPD_A_STATUS    8'h30
`define CPD_A_LAST_PV   8'h34
// reset values
`define CPD_RST_NODE    7'h40
`define CPD_RST_PDO_COB 32'h0000_01C0
`define CPD_RST_TX_TYPE 8'hFF
`define CPD_RST_INHIBIT 16'h0000
`define CPD_RST_EVT_TMR 16'h03E8
`define CPD_RST_DELTA   32'h0000_0000
`define CPD_RST_HB_TIME 16'h0000
`define CPD_RST_DIGITS  8'h00
`define CPD_RST_SCALE   32'h0000_0001
`define CPD_BITRATE_KB  16'h01F4
// field positions and codes
`define CPD_PDO_INVALID 31
`define CPD_TYPE_EVENT  8'hFF
`define CPD_COB_NMT     11'h000
`define CPD_COB_HB_B    11'h700
`define CPD_NMT_START   8'h01
`define CPD_NMT_STOP    8'h02
`define CPD_NMT_PREOP   8'h80
`define CPD_NMT_RSTNODE 8'h81
`define CPD_NMT_RSTCOMM 8'h82
`define CPD_HB_BOOT     8'h00
`define CPD_HB_STOP     8'h04
`define CPD_HB_OP       8'h05
`define CPD_HB_PREOP    8'h7F
`define CPD_PDO_LEN     4'h6
// timing
`define CPD_CLK_NS      20
`define CPD_MS_NS       1000000
`define CPD_INH_NS      100000
`define CPD_MS_CYC      (`CPD_MS_NS / `CPD_CLK_NS)
`define CPD_INH_CYC     (`CPD_INH_NS / `CPD_CLK_NS)
`endif

//--- src/cpd_pkg.sv
// types of the measurement pdo node
package cpd_pkg;
    // nmt communication state, one-hot
    typedef enum logic [3:0] {
        CPD_BOOT  = 4'b0001,
        CPD_PREOP = 4'b0010,
        CPD_OPER  = 4'b0100,
        CPD_STOP  = 4'b1000
    } cpd_nmt_t;
    // one can frame, byte 0 in data[7:0] goes first
    typedef struct packed {
        logic [10:0] id;
        logic [3:0]  len;
        logic [63:0] data;
    } cpd_frame_t;
    // one measurement sample
    typedef struct packed {
        logic        valid;
        logic [31:0] value;
        logic        pos_ovf;
        logic        neg_ovf;
    } cpd_meas_t;
    // whole state of the node
    typedef struct packed {
        cpd_nmt_t    nmt;
        logic [31:0] pdo_comm;
        logic [7:0]  tx_type;
        logic [15:0] inhibit;
        logic [15:0] evt_tmr;
        logic [31:0] delta;
        logic [15:0] hb_time;
        logic [31:0] thr1;
        logic [31:0] thr2;
        logic [6:0]  node;
        logic [31:0] scale;
        logic [7:0]  digits;
        logic [31:0] unit;
        logic [31:0] ms_div;
        logic [31:0] inh_div;
        logic [15:0] evt_cnt;
        logic [15:0] hb_cnt;
        logic [15:0] inh_cnt;
        logic        evt_due;
        logic        hb_due;
        logic        boot_due;
        logic [31:0] cur_pv;
        logic        pos_ovf;
        logic        neg_ovf;
        logic [31:0] last_pv;
        logic [1:0]  alarm;
        cpd_frame_t  tx;
        logic        tx_valid;
        logic [31:0] prdata;
    } cpd_state_t;
endpackage

//--- src/cpd_pdo_node.sv
// measurement pdo node: nmt, heartbeat, pdo send conditions, apb regs
`timescale 1ns/100ps
`default_nettype none
`include "cpd_cfg.svh"
module cpd_pdo_node #(
    parameter int MS_CYC  = `CPD_MS_CYC,   // cycles per millisecond
    parameter int INH_CYC = `CPD_INH_CYC   // cycles per 100 us step
) (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // measurement from the front end
    input  wire cpd_pkg::cpd_meas_t i_meas,
    // received can frame
    input  wire logic              i_rx_valid,
    input  wire cpd_pkg::cpd_frame_t i_rx,
    // frame to transmit
    output cpd_pkg::cpd_frame_t    o_tx,
    output logic                   o_tx_valid,
    input  wire logic              i_tx_ready,
    // threshold switch outputs and state
    output logic [1:0]             o_alarm_sw,
    output cpd_pkg::cpd_nmt_t      o_nmt_state
);
    // refuse prescaler counts below one
    if (MS_CYC < 1 || INH_CYC < 1) begin : g_bad_param
        $error("cpd_pdo_node: prescaler counts must be at least one");
    end

    cpd_pkg::cpd_state_t s_r;     // registered state
    cpd_pkg::cpd_state_t s_nxt;   // next state

    // builds a frame from id, length and payload
    function automatic cpd_pkg::cpd_frame_t mk_frame(
        input logic [10:0] id,
        input logic [3:0]  len,
        input logic [63:0] data);
        cpd_pkg::cpd_frame_t f;
        f.id   = id;
        f.len  = len;
        f.data = data;
        return f;
    endfunction

    // heartbeat code for a nmt state
    function automatic logic [7:0] hb_code(input cpd_pkg::cpd_nmt_t n);
        logic [7:0] c;
        c = `CPD_HB_BOOT;
        unique case (n)
            cpd_pkg::CPD_BOOT:  c = `CPD_HB_BOOT;
            cpd_pkg::CPD_PREOP: c = `CPD_HB_PREOP;
            cpd_pkg::CPD_OPER:  c = `CPD_HB_OP;
            cpd_pkg::CPD_STOP:  c = `CPD_HB_STOP;
            default:            c = `CPD_HB_BOOT;
        endcase
        return c;
    endfunction

    // address decode
    logic        apb_setup;     // setup phase of a transfer
    logic        apb_wr;        // write takes effect now
    logic        addr_ok;       // address maps to a register
    logic [31:0] rd_val;        // read mux output
    // nmt decode
    logic        nmt_hit;       // nmt frame for this node
    logic [7:0]  nmt_cmd;       // command byte
    // pdo trigger terms
    logic [32:0] diff;          // signed difference to last sent
    logic [32:0] mag;           // its magnitude
    logic        delta_hit;     // change reached delta
    logic        inh_busy;      // inhibit time still running
    logic        pdo_ok;        // pdo may be sent at all
    logic        pdo_go;        // pdo is sent this cycle
    logic [7:0]  in_stat;       // input status byte
    logic [7:0]  al_stat;       // alarm status byte
    logic        tx_free;       // output slot can take a frame

    // read mux of all readable registers
    always_comb begin
        addr_ok = 1'b1;
        rd_val  = 32'h0000_0000;
        unique case (i_paddr)
            `CPD_A_PDO_COMM: rd_val = s_r.pdo_comm;
            `CPD_A_TX_TYPE:  rd_val = 32'(s_r.tx_type);
            `CPD_A_INHIBIT:  rd_val = 32'(s_r.inhibit);
            `CPD_A_EVT_TMR:  rd_val = 32'(s_r.evt_tmr);
            `CPD_A_DELTA:    rd_val = s_r.delta;
            `CPD_A_HB_TIME:  rd_val = 32'(s_r.hb_time);
            `CPD_A_THRESH1:  rd_val = s_r.thr1;
            `CPD_A_THRESH2:  rd_val = s_r.thr2;
            // bit rate is fixed, shown beside the node id
            `CPD_A_NODE_ID:  rd_val = {`CPD_BITRATE_KB, 9'h000, s_r.node};
            `CPD_A_SCALE:    rd_val = s_r.scale;
            `CPD_A_DIGITS:   rd_val = 32'(s_r.digits);
            `CPD_A_UNIT:     rd_val = s_r.unit;
            `CPD_A_STATUS:   rd_val = {14'h0000, s_r.alarm, in_stat,
                                       4'h0, s_r.nmt};
            `CPD_A_LAST_PV:  rd_val = s_r.last_pv;
            default:         addr_ok = 1'b0;
        endcase
    end

    // apb phases
    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr    = i_psel & i_penable & i_pwrite & addr_ok;

    // nmt frame: id 0, byte0 command, byte1 node or 0 for all
    assign nmt_cmd = i_rx.data[7:0];
    assign nmt_hit = i_rx_valid && i_rx.id == `CPD_COB_NMT &&
                     i_rx.len >= 4'h2 &&
                     (i_rx.data[15:8] == 8'h00 ||
                      i_rx.data[15:8] == {1'b0, s_r.node});

    // delta against the value of the last pdo sent
    assign diff = {s_r.cur_pv[31], s_r.cur_pv} -
                  {s_r.last_pv[31], s_r.last_pv};
    assign mag  = diff[32] ? 33'(-diff) : diff;
    assign delta_hit = (s_r.delta != 32'h0000_0000) &&
                       (mag >= {1'b0, s_r.delta});

    // status bytes, unused bits held at zero
    assign in_stat = {5'h00, s_r.neg_ovf, s_r.pos_ovf, 1'b0};
    assign al_stat = {6'h00, s_r.alarm};

    // inhibit counts 100 us steps since the last send
    assign inh_busy = (s_r.inhibit != 16'h0000) &&
                      (s_r.inh_cnt < s_r.inhibit);

    // send only when operational and valid bit clear
    assign pdo_ok = (s_r.nmt == cpd_pkg::CPD_OPER) &&
                    !s_r.pdo_comm[`CPD_PDO_INVALID];

    assign tx_free = ~s_r.tx_valid;

    // event timer triggers type 255 only, never 254
    assign pdo_go = tx_free && pdo_ok && !inh_busy &&
                    !s_r.boot_due && !s_r.hb_due &&
                    (s_r.tx_type == `CPD_TYPE_EVENT) &&
                    (s_r.evt_due || delta_hit);

    // next-state logic of the whole node
    always_comb begin
        s_nxt = s_r;

        // apb read data is captured in the setup phase
        if (apb_setup) begin
            s_nxt.prdata = rd_val;
        end

        // sample the front end and run the threshold switches
        if (i_meas.valid) begin
            s_nxt.cur_pv  = i_meas.value;
            s_nxt.pos_ovf = i_meas.pos_ovf;
            s_nxt.neg_ovf = i_meas.neg_ovf;
            s_nxt.alarm[0] = $signed(i_meas.value) >= $signed(s_r.thr1);
            s_nxt.alarm[1] = $signed(i_meas.value) >= $signed(s_r.thr2);
        end

        // ms prescaler feeds event and heartbeat timers
        if (s_r.ms_div >= 32'(MS_CYC - 1)) begin
            s_nxt.ms_div = 32'h0000_0000;
            if (s_r.evt_tmr != 16'h0000) begin
                if (s_r.evt_cnt >= s_r.evt_tmr - 16'h0001) begin
                    s_nxt.evt_cnt = 16'h0000;
                    s_nxt.evt_due = 1'b1;
                end else begin
                    s_nxt.evt_cnt = s_r.evt_cnt + 16'h0001;
                end
            end
            // zero heartbeat time disables it
            if (s_r.hb_time != 16'h0000 && s_r.nmt != cpd_pkg::CPD_BOOT) begin
                if (s_r.hb_cnt >= s_r.hb_time - 16'h0001) begin
                    s_nxt.hb_cnt = 16'h0000;
                    s_nxt.hb_due = 1'b1;
                end else begin
                    s_nxt.hb_cnt = s_r.hb_cnt + 16'h0001;
                end
            end
        end else begin
            s_nxt.ms_div = s_r.ms_div + 32'h0000_0001;
        end

        // inhibit prescaler, count stops once it reaches the limit
        if (s_r.inh_div >= 32'(INH_CYC - 1)) begin
            s_nxt.inh_div = 32'h0000_0000;
            if (inh_busy) begin
                s_nxt.inh_cnt = s_r.inh_cnt + 16'h0001;
            end
        end else begin
            s_nxt.inh_div = s_r.inh_div + 32'h0000_0001;
        end

        // transmit slot empties on the partner's ready
        if (s_r.tx_valid && i_tx_ready) begin
            s_nxt.tx_valid = 1'b0;
        end

        // arbitration: bootup, heartbeat, pdo
        if (tx_free && s_r.boot_due) begin
            s_nxt.tx = mk_frame(`CPD_COB_HB_B | {4'h0, s_r.node}, 4'h1,
                                {56'h0, `CPD_HB_BOOT});
            s_nxt.tx_valid = 1'b1;
            s_nxt.boot_due = 1'b0;
            s_nxt.nmt      = cpd_pkg::CPD_PREOP;
        end else if (tx_free && s_r.hb_due) begin
            s_nxt.tx = mk_frame(`CPD_COB_HB_B | {4'h0, s_r.node}, 4'h1,
                                {56'h0, hb_code(s_r.nmt)});
            s_nxt.tx_valid = 1'b1;
            s_nxt.hb_due   = 1'b0;
        end else if (pdo_go) begin
            // value lsb first, then input status, then alarm status
            s_nxt.tx = mk_frame(s_r.pdo_comm[10:0], `CPD_PDO_LEN,
                                {16'h0000, al_stat, in_stat,
                                 s_r.cur_pv});
            s_nxt.tx_valid = 1'b1;
            s_nxt.last_pv  = s_r.cur_pv;
            s_nxt.evt_cnt  = 16'h0000;
            s_nxt.evt_due  = 1'b0;
            s_nxt.inh_cnt  = 16'h0000;
            s_nxt.inh_div  = 32'h0000_0000;
            // a tick landing now is kept, but only with a 1 ms event timer
            if (s_r.ms_div >= 32'(MS_CYC - 1) && s_r.evt_tmr == 16'h0001) begin
                s_nxt.evt_due = 1'b1;
            end
        end

        // register writes from software
        if (apb_wr) begin
            unique case (i_paddr)
                `CPD_A_PDO_COMM: s_nxt.pdo_comm = i_pwdata;
                `CPD_A_TX_TYPE:  s_nxt.tx_type  = i_pwdata[7:0];
                `CPD_A_INHIBIT:  s_nxt.inhibit  = i_pwdata[15:0];
                `CPD_A_EVT_TMR:  s_nxt.evt_tmr  = i_pwdata[15:0];
                `CPD_A_DELTA:    s_nxt.delta    = i_pwdata;
                `CPD_A_HB_TIME:  s_nxt.hb_time  = i_pwdata[15:0];
                `CPD_A_THRESH1:  s_nxt.thr1     = i_pwdata;
                `CPD_A_THRESH2:  s_nxt.thr2     = i_pwdata;
                `CPD_A_NODE_ID:  s_nxt.node     = i_pwdata[6:0];
                // scaling applied upstream; digits kept as set
                `CPD_A_SCALE:    s_nxt.scale    = i_pwdata;
                `CPD_A_DIGITS:   s_nxt.digits   = i_pwdata[7:0];
                // unit touches nothing but itself
                `CPD_A_UNIT:     s_nxt.unit     = i_pwdata;
                default: ; // read-only or unmapped: no effect
            endcase
        end

        // nmt commands win over software writes
        if (nmt_hit) begin
            unique case (nmt_cmd)
                `CPD_NMT_START: begin
                    if (s_r.nmt != cpd_pkg::CPD_BOOT) begin
                        s_nxt.nmt = cpd_pkg::CPD_OPER;
                    end
                end
                `CPD_NMT_STOP: begin
                    if (s_r.nmt != cpd_pkg::CPD_BOOT) begin
                        s_nxt.nmt = cpd_pkg::CPD_STOP;
                    end
                end
                `CPD_NMT_PREOP: begin
                    if (s_r.nmt != cpd_pkg::CPD_BOOT) begin
                        s_nxt.nmt = cpd_pkg::CPD_PREOP;
                    end
                end
                `CPD_NMT_RSTNODE, `CPD_NMT_RSTCOMM: begin
                    // both resets restore the comm set and reboot
                    s_nxt.nmt      = cpd_pkg::CPD_BOOT;
                    s_nxt.boot_due = 1'b1;
                    s_nxt.hb_due   = 1'b0;
                    s_nxt.evt_due  = 1'b0;
                    s_nxt.evt_cnt  = 16'h0000;
                    s_nxt.hb_cnt   = 16'h0000;
                    s_nxt.node     = `CPD_RST_NODE;
                    s_nxt.pdo_comm = `CPD_RST_PDO_COB;
                    s_nxt.tx_type  = `CPD_RST_TX_TYPE;
                    s_nxt.inhibit  = `CPD_RST_INHIBIT;
                    s_nxt.evt_tmr  = `CPD_RST_EVT_TMR;
                    s_nxt.hb_time  = `CPD_RST_HB_TIME;
                    // node reset also restores app settings
                    if (nmt_cmd == `CPD_NMT_RSTNODE) begin
                        s_nxt.delta  = `CPD_RST_DELTA;
                        s_nxt.thr1   = 32'h7FFF_FFFF;
                        s_nxt.thr2   = 32'h7FFF_FFFF;
                        s_nxt.scale  = `CPD_RST_SCALE;
                        s_nxt.digits = `CPD_RST_DIGITS;
                        s_nxt.unit   = 32'h0000_0000;
                    end
                end
                default: ; // unknown command byte is ignored
            endcase
        end
    end

    // the one state register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r          <= '0;
            s_r.nmt      <= cpd_pkg::CPD_BOOT;
            s_r.boot_due <= 1'b1;
            s_r.node     <= `CPD_RST_NODE;
            s_r.pdo_comm <= `CPD_RST_PDO_COB;
            s_r.tx_type  <= `CPD_RST_TX_TYPE;
            s_r.inhibit  <= `CPD_RST_INHIBIT;
            s_r.evt_tmr  <= `CPD_RST_EVT_TMR;
            s_r.delta    <= `CPD_RST_DELTA;
            s_r.hb_time  <= `CPD_RST_HB_TIME;
            s_r.thr1     <= 32'h7FFF_FFFF;
            s_r.thr2     <= 32'h7FFF_FFFF;
            s_r.scale    <= `CPD_RST_SCALE;
            s_r.digits   <= `CPD_RST_DIGITS;
        end else begin
            s_r <= s_nxt;
        end
    end

    // apb answers in the first access cycle, no wait states
    assign o_pready    = i_psel & i_penable;
    assign o_pslverr   = i_psel & i_penable & ~addr_ok;
    assign o_prdata    = s_r.prdata;
    assign o_tx        = s_r.tx;
    assign o_tx_valid  = s_r.tx_valid;
    assign o_alarm_sw  = s_r.alarm;
    assign o_nmt_state = s_r.nmt;
endmodule
`default_nettype wire

//--- tb/cpd_master_model.sv
// behavioural can master: sends nmt commands, accepts node frames
`timescale 1ns/100ps
`default_nettype none
module cpd_master_model (
    input  wire logic           i_clk,
    input  wire logic           i_stall,    // high: frames held back
    input  wire logic           i_tx_valid, // node offers a frame
    output logic                o_tx_ready, // frame taken at this edge
    output logic                o_rx_valid, // one-cycle command pulse
    output cpd_pkg::cpd_frame_t o_rx        // command frame
);
    // idle bus at start
    initial begin
        o_rx_valid = 1'b0;
        o_rx       = '0;
    end
    // stalled: frame left waiting
    assign o_tx_ready = i_tx_valid && !i_stall;
    // nmt frame: byte 0 command, byte 1 target node (0 = all)
    task automatic send(input logic [7:0] c, input logic [7:0] node);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx       <= '{11'h000, 4'h2, {48'h0, node, c}};
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        // released lines show the inverse
        o_rx       <= ~o_rx;
    endtask
endmodule
`default_nettype wire

//--- tb/cpd_pdo_node_chk.sv
// concurrent checks on the pdo node ports
`timescale 1ns/100ps
`default_nettype none
module cpd_pdo_node_chk (
    input wire logic                i_clk,
    input wire logic                i_sys_rst,
    input wire logic                i_psel,
    input wire logic                i_penable,
    input wire logic [7:0]          i_paddr,
    input wire logic                o_pready,
    input wire logic                o_pslverr,
    input wire logic                i_rx_valid,
    input wire cpd_pkg::cpd_frame_t i_rx,
    input wire cpd_pkg::cpd_frame_t o_tx,
    input wire logic                o_tx_valid,
    input wire logic                i_tx_ready,
    input wire cpd_pkg::cpd_nmt_t   o_nmt_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // nmt command to this node out of boot
    sequence s_cmd(c);
        i_rx_valid && i_rx.id == 11'h000 && i_rx.len >= 4'h2 &&
        i_rx.data[7:0] == c && o_nmt_state != cpd_pkg::CPD_BOOT &&
        (i_rx.data[15:8] == 8'h40 || i_rx.data[15:8] == 8'h00);
    endsequence
    // bootup frame, node pre-operational
    sequence s_boot;
        o_tx_valid && o_tx.id == 11'h740 && o_tx.len == 4'h1 &&
        o_tx.data[7:0] == 8'h00 && o_nmt_state == cpd_pkg::CPD_PREOP;
    endsequence
    // a new measurement frame appears
    sequence s_pdo_new;
        $rose(o_tx_valid) && o_tx.id == 11'h1C0;
    endsequence
    a_boot_frame: assert property ($fell(i_sys_rst) |->
        !o_tx_valid ##1 s_boot) else $error("bootup frame missing");
    a_pdo_oper: assert property (s_pdo_new |->
        $past(o_nmt_state) == cpd_pkg::CPD_OPER)
        else $error("pdo outside operational");
    a_pdo_layout: assert property (s_pdo_new |->
        o_tx.len == 4'h6 && o_tx.data[63:48] == 16'h0 &&
        o_tx.data[47:42] == 6'h0 && o_tx.data[39:35] == 5'h0 &&
        o_tx.data[32] == 1'b0) else $error("pdo layout wrong");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx)) else $error("frame dropped");
    a_nmt_start: assert property (s_cmd(8'h01) |=>
        o_nmt_state == cpd_pkg::CPD_OPER) else $error("start missed");
    a_nmt_stop: assert property (s_cmd(8'h02) |=>
        o_nmt_state == cpd_pkg::CPD_STOP) else $error("stop missed");
    a_apb_ready: assert property (i_psel && i_penable |-> o_pready)
        else $error("apb ready late");
    a_apb_unmapped: assert property (i_psel && i_penable &&
        i_paddr > 8'h34 |-> o_pslverr) else $error("no slave error");
endmodule
bind cpd_pdo_node cpd_pdo_node_chk u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_rx_valid(i_rx_valid), .i_rx(i_rx), .o_tx(o_tx),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
    .o_nmt_state(o_nmt_state));
`default_nettype wire

//--- tb/cpd_pdo_node_test.sv
// self-checking bench of the measurement pdo node
`timescale 1ns/100ps
`default_nettype none
module cpd_pdo_node_test;
    typedef struct { logic [7:0] a; logic [31:0] v; } cpd_row_t;
    logic                i_clk = 1'b0;     // 50 mhz core clock
    logic                i_sys_rst = 1'b1; // held over first edges
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, rd;
    logic                pready, pslverr, err, stall = 1'b0;
    logic                rx_valid, tx_valid, tx_ready;
    cpd_pkg::cpd_meas_t  meas = '0;        // front end sample
    cpd_pkg::cpd_frame_t rx, tx;
    logic [1:0]          alarm;
    cpd_pkg::cpd_nmt_t   nmt;
    logic [63:0]         pdo_d;            // last pdo payload taken
    logic [7:0]          hb_d = 8'h00;     // last heartbeat state byte
    int failures = 0, compares = 0, cyc = 0, last = 0, gap = 0;
    int pdo_n = 0, boot_n = 0;
    // reset values; 0x38 unmapped, errors
    cpd_row_t regs [14] = '{'{8'h00, 32'h1C0}, '{8'h04, 32'hFF},
        '{8'h08, 32'h0}, '{8'h0C, 32'h3E8}, '{8'h10, 32'h0},
        '{8'h14, 32'h0}, '{8'h18, 32'h7FFFFFFF}, '{8'h1C, 32'h7FFFFFFF},
        '{8'h20, 32'h01F40040}, '{8'h24, 32'h1}, '{8'h28, 32'h0},
        '{8'h2C, 32'h0}, '{8'h30, 32'h2}, '{8'h38, 32'h0}};
    // nmt command, then {heartbeat byte, state} expected
    cpd_row_t cmds [5] = '{'{8'h80, 32'h7F2}, '{8'h01, 32'h054},
        '{8'h02, 32'h048}, '{8'h82, 32'h002}, '{8'h81, 32'h002}};
    cpd_pdo_node #(.MS_CYC(10), .INH_CYC(5)) dut (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_meas(meas), .i_rx_valid(rx_valid), .i_rx(rx), .o_tx(tx),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_alarm_sw(alarm), .o_nmt_state(nmt));
    cpd_master_model m (.i_clk(i_clk), .i_stall(stall),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .o_rx_valid(rx_valid), .o_rx(rx));
    always #10 i_clk = ~i_clk;
    // monitor of frames the master took
    always @(posedge i_clk) begin
        cyc++;
        if (tx_valid && tx_ready && tx.id == 11'h1C0) begin
            pdo_n++;
            pdo_d = tx.data;
            gap = cyc - last;
            last = cyc;
        end
        if (tx_valid && tx_ready && tx.id == 11'h740) begin
            if (tx.data[7:0] == 8'h00) boot_n++;
            else hb_d = tx.data[7:0];
        end
    end
    task automatic chk(input string n, input logic [63:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic sample(input logic [31:0] v, input logic p, q);
        @(posedge i_clk);
        meas <= '{1'b1, v, p, q};
        @(posedge i_clk);
        meas.valid <= 1'b0;
    endtask
    // next pdo taken within a bounded span
    task automatic wait_pdo;
        int n0, k;
        n0 = pdo_n;
        for (k = 0; k < 300 && pdo_n == n0; k++) @(posedge i_clk);
        chk("pdo sent", pdo_n > n0, 1'b1);
    endtask
    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        stop_test;
    end
    initial begin
        idle(2);
        i_sys_rst <= 1'b0;
        idle(3);
        chk("boot frames", boot_n, 1);
        foreach (regs[i]) begin
            apb(1'b0, regs[i].a, 32'h0);
            chk("reg read", rd, regs[i].v);
            chk("reg error", err, regs[i].a == 8'h38);
        end
        $display("test defaults done");
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h18, 32'h0);
        sample(32'h12345678, 1'b1, 1'b0);
        idle(80);
        chk("preop pdos", pdo_n, 0);
        stall <= 1'b1;
        m.send(8'h01, 8'h00);
        idle(1);
        chk("nmt state", nmt, cpd_pkg::CPD_OPER);
        idle(40);
        stall <= 1'b0;
        wait_pdo;
        chk("payload", pdo_d[47:0], 48'h01_02_12345678);
        chk("alarm", alarm, 2'b01);
        $display("test first pdo done");
        apb(1'b1, 8'h08, 32'h4);
        apb(1'b1, 8'h0C, 32'h1);
        sample(32'hFFFFFF00, 1'b0, 1'b1);
        repeat (3) wait_pdo;
        chk("inhibit gap", gap >= 20 && gap < 30, 1'b1);
        chk("payload", pdo_d[47:0], 48'h00_04_FFFFFF00);
        apb(1'b1, 8'h08, 32'h0);
        repeat (3) wait_pdo;
        chk("event gap", gap >= 10 && gap <= 12, 1'b1);
        apb(1'b1, 8'h04, 32'hFE);
        idle(2);
        gap = pdo_n;
        idle(60);
        chk("type 254 pdos", pdo_n, gap);
        apb(1'b1, 8'h0C, 32'hFFFF);
        apb(1'b1, 8'h00, 32'h800001C0);
        apb(1'b1, 8'h04, 32'hFF);
        apb(1'b1, 8'h10, 32'd100);
        idle(2);
        gap = pdo_n;
        sample(32'hFFFFFF64, 1'b0, 1'b0);
        idle(30);
        chk("invalid pdos", pdo_n, gap);
        apb(1'b1, 8'h00, 32'h1C0);
        wait_pdo;
        gap = pdo_n;
        sample(32'hFFFFFF01, 1'b0, 1'b0);
        idle(40);
        chk("small delta", pdo_n, gap);
        sample(32'hFFFFFF00, 1'b0, 1'b0);
        wait_pdo;
        chk("delta value", pdo_d[31:0], 32'hFFFFFF00);
        apb(1'b1, 8'h2C, 32'h3);
        apb(1'b1, 8'h24, 32'h5);
        apb(1'b0, 8'h24, 32'h0);
        chk("scale", rd, 32'h5);
        apb(1'b0, 8'h28, 32'h0);
        chk("digits", rd, 32'h0);
        $display("test send conditions done");
        apb(1'b1, 8'h14, 32'h1);
        foreach (cmds[i]) begin
            m.send(cmds[i].a, 8'h40);
            idle(2); // old-state frame drains
            hb_d = 8'h00;
            idle(23);
            chk("nmt state", nmt, cmds[i].v[3:0]);
            chk("heartbeat", hb_d, cmds[i].v[11:4]);
        end
        chk("boot frames", boot_n, 3);
        apb(1'b0, 8'h18, 32'h0);
        chk("thresh reset", rd, 32'h7FFFFFFF);
        i_sys_rst <= 1'b1;
        idle(2);
        i_sys_rst <= 1'b0;
        idle(4);
        chk("boot frames", boot_n, 4);
        chk("nmt state", nmt, cpd_pkg::CPD_PREOP);
        $display("test nmt and reset done");
        stop_test;
    end
endmodule
`default_nettype wire
